//--- hw/ckc_pkg.sv
// ****************************************************************
// clocktick counting constants
// ****************************************************************
package ckc_pkg;
	// sizes
	localparam int          NUM_CNT   = 18;
	localparam int          NUM_ESEL  = 8;
	localparam int          CNT_W     = 32;
	localparam int          ADR_W     = 12;
	// register offsets, byte addresses
	localparam logic [11:0] ADR_CNT   = 12'h000;
	localparam logic [11:0] ADR_CCFG  = 12'h080;
	localparam logic [11:0] ADR_ESEL  = 12'h100;
	localparam logic [11:0] ADR_TSCLO = 12'h180;
	localparam logic [11:0] ADR_TSCHI = 12'h184;
	localparam logic [11:0] ADR_STAT  = 12'h188;
	localparam logic [11:0] ADR_MASK  = 12'h18C;
	localparam logic [11:0] ADR_STATE = 12'h190;
	// counter_config_register fields
	localparam int          CCFG_EN   = 12;
	localparam int          CCFG_SEL  = 13;
	localparam int          CCFG_CMP  = 18;
	localparam int          CCFG_CMPL = 19;
	localparam int          CCFG_THR  = 20;
	localparam int          CCFG_OVF  = 31;
	localparam logic [3:0]  THR_ALL   = 4'hF;
	// event_select_register fields
	localparam int          ESEL_T1U  = 0;
	localparam int          ESEL_T1K  = 1;
	localparam int          ESEL_T0U  = 2;
	localparam int          ESEL_T0K  = 3;
	localparam int          ESEL_RUN  = 9;
	localparam int          ESEL_EVT  = 25;
	localparam logic [5:0]  EVT_NULL  = 6'h00;
	localparam logic [5:0]  EVT_POWER = 6'h13;
	// reset values
	localparam logic [31:0] CCFG_RST  = 32'h0000_0000;
	localparam logic [31:0] ESEL_RST  = 32'h0000_0000;
	localparam logic [63:0] TSC_RST   = 64'h0;
endpackage

//--- hw/ckc_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// per-counter filter carrier
// ****************************************************************
interface ckc_filt_if;
	logic [31:0] ccfg;
	logic [31:0] esel;
	logic [1:0]  halted;
	logic [1:0]  kernel;
	logic        pwr_save;
	logic [3:0]  ext_cnt;
	logic [3:0]  inc;
	modport top  (output ccfg, esel, halted, kernel, pwr_save, ext_cnt,
		input inc);
	modport filt (input ccfg, esel, halted, kernel, pwr_save, ext_cnt,
		output inc);
endinterface
`default_nettype wire

//--- hw/ckc_thresh_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// event qualification and threshold filter
// ****************************************************************
module ckc_thresh_filter
	import ckc_pkg::*;
(
	ckc_filt_if.filt f
);
	logic [5:0] evt;
	logic       run0;
	logic       run1;
	logic       q0;
	logic       q1;
	logic [3:0] q;
	logic [3:0] thr;
	logic       pass;

	// qualify by thread state and privilege, then compare
	always_comb begin
		evt  = f.esel[ESEL_EVT +: 6];
		run0 = ~f.halted[0] & ~f.pwr_save;
		run1 = ~f.halted[1] & ~f.pwr_save;
		q0   = run0 & (f.kernel[0] ? f.esel[ESEL_T0K] : f.esel[ESEL_T0U]);
		q1   = run1 & (f.kernel[1] ? f.esel[ESEL_T1K] : f.esel[ESEL_T1U]);
		if (evt == EVT_POWER) begin
			q = f.esel[ESEL_RUN] ? 4'(q0) + 4'(q1) : 4'h0;
		end else begin
			q = (q0 | q1) ? f.ext_cnt : 4'h0;
		end
		thr  = f.ccfg[CCFG_THR +: 4];
		// threshold 15 with complement passes any count
		pass = f.ccfg[CCFG_CMPL] ? (q <= thr) : (q > thr);
		// null event may leave the counter dead
		if (!f.ccfg[CCFG_EN] || evt == EVT_NULL) begin
			f.inc = 4'h0;
		end else if (f.ccfg[CCFG_CMP]) begin
			f.inc = {3'b000, pass};
		end else begin
			f.inc = q;
		end
	end
endmodule // ckc_thresh_filter
`default_nettype wire

//--- hw/ckc_counter_top.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ckc_counter_top
	import ckc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic             wb_we_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic [1:0]       halted_i,
	input  wire logic [1:0]       kernel_mode_i,
	input  wire logic             pwr_save_req_i,
	input  wire logic [3:0]       ext_evt_cnt_i,
	input  wire logic             bus_clk_run_i,
	input  wire logic             sleep_pin_i,
	input  wire logic             tsc_read_i,
	output logic      [63:0]      tsc_value_o,
	output logic                  pwr_save_o,
	output logic                  irq_o
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// word hit inside an array window starting at base
	function automatic logic hit(input logic [ADR_W-1:0] a,
		input logic [ADR_W-1:0] base, input int n, input int i);
		return a == base + ADR_W'(4 * i);
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic [CNT_W-1:0] cnt_r      [NUM_CNT];
	logic [31:0]      ccfg_r     [NUM_CNT];
	logic [31:0]      esel_r     [NUM_ESEL];
	logic [CNT_W-1:0] cnt_nxt    [NUM_CNT];
	logic [3:0]       inc_w      [NUM_CNT];
	logic [NUM_CNT-1:0] carry;
	logic [NUM_CNT-1:0] ovf_evt;
	logic [NUM_CNT-1:0] cnt_wr;
	logic [NUM_CNT-1:0] ccfg_wr;
	logic [NUM_CNT-1:0] stat_r;
	logic [NUM_CNT-1:0] mask_r;
	logic [63:0]      tsc_r;
	logic [31:0]      tsc_hi_snap_r;
	logic [63:0]      tsc_value_r;
	logic [1:0]       halted_q_r;
	logic             pwr_save_r;
	logic             irq_r;
	logic             ack_r;
	logic [31:0]      dat_r;
	logic [31:0]      rd_nxt;
	logic             wb_req;
	logic             wr;
	logic             pmc_on;
	logic             tsc_run;

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr     = wb_req & wb_we_i;

	// ****************************************************************
	// package power state
	// ****************************************************************
	// halt seen one cycle late, so ticks leak into the halt edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halted_q_r <= 2'b00;
		end else begin
			halted_q_r <= halted_i;
		end
	end

	// power saving is refused until every thread is halted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_save_r <= 1'b0;
		end else begin
			pwr_save_r <= pwr_save_req_i & (&halted_i);
		end
	end

	// counters keep power while any one thread runs
	assign pmc_on = ~(&halted_q_r) & ~pwr_save_r;

	// ****************************************************************
	// filters, one per counter
	// ****************************************************************
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_filt
		ckc_filt_if fi ();
		assign fi.ccfg     = ccfg_r[i];
		// any counter may pick any selector
		assign fi.esel     = esel_r[ccfg_r[i][CCFG_SEL +: 3]];
		assign fi.halted   = halted_q_r;
		assign fi.kernel   = kernel_mode_i;
		assign fi.pwr_save = pwr_save_r;
		assign fi.ext_cnt  = ext_evt_cnt_i;
		assign inc_w[i]    = fi.inc;
		ckc_thresh_filter u_filt (
			.f (fi.filt)
		);
	end

	// ****************************************************************
	// performance counters
	// ****************************************************************
	// sums, carries and write hits for every counter
	always_comb begin
		for (int i = 0; i < NUM_CNT; i++) begin
			{carry[i], cnt_nxt[i]} = {1'b0, cnt_r[i]}
				+ (CNT_W+1)'(inc_w[i]);
			cnt_wr[i]  = wr & hit(wb_adr_i, ADR_CNT, NUM_CNT, i);
			ccfg_wr[i] = wr & hit(wb_adr_i, ADR_CCFG, NUM_CNT, i);
			ovf_evt[i] = pmc_on & carry[i] & ~cnt_wr[i];
		end
	end

	// a software write to a counter wins over its increment
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CNT; i++) begin
				if (cnt_wr[i]) begin
					cnt_r[i] <= merge(cnt_r[i], wb_dat_i, wb_sel_i);
				end else if (pmc_on) begin
					cnt_r[i] <= cnt_nxt[i];
				end
			end
		end
	end

	// config words; overflow flag is sticky and set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				ccfg_r[i] <= CCFG_RST;
			end
		end else begin
			for (int i = 0; i < NUM_CNT; i++) begin
				if (ccfg_wr[i]) begin
					ccfg_r[i] <= merge(ccfg_r[i], wb_dat_i, wb_sel_i)
						| (32'(ovf_evt[i]) << CCFG_OVF);
				end else if (ovf_evt[i]) begin
					ccfg_r[i][CCFG_OVF] <= 1'b1;
				end
			end
		end
	end

	// event selectors, written by software only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_ESEL; i++) begin
				esel_r[i] <= ESEL_RST;
			end
		end else begin
			for (int i = 0; i < NUM_ESEL; i++) begin
				if (wr && hit(wb_adr_i, ADR_ESEL, NUM_ESEL, i)) begin
					esel_r[i] <= merge(esel_r[i], wb_dat_i, wb_sel_i);
				end
			end
		end
	end

	// ****************************************************************
	// time-stamp counter
	// ****************************************************************
	assign tsc_run = bus_clk_run_i & ~sleep_pin_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tsc_r <= TSC_RST;
		end else if (wr && wb_adr_i == ADR_TSCLO) begin
			tsc_r[31:0] <= merge(tsc_r[31:0], wb_dat_i, wb_sel_i);
		end else if (wr && wb_adr_i == ADR_TSCHI) begin
			tsc_r[63:32] <= merge(tsc_r[63:32], wb_dat_i, wb_sel_i);
		end else if (tsc_run) begin
			tsc_r <= tsc_r + 64'h1;
		end
	end

	// dedicated read port captures the whole count at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tsc_value_r <= TSC_RST;
		end else if (tsc_read_i) begin
			tsc_value_r <= tsc_r;
		end
	end

	// low-word bus read freezes the high word so the pair is coherent
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tsc_hi_snap_r <= 32'h0;
		end else if (wb_req && !wb_we_i && wb_adr_i == ADR_TSCLO) begin
			tsc_hi_snap_r <= tsc_r[63:32];
		end
	end

	// ****************************************************************
	// interrupt
	// ****************************************************************
	// write one to clear; an overflow in the same cycle stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~((wr && wb_adr_i == ADR_STAT)
				? wb_dat_i[NUM_CNT-1:0] : '0)) | ovf_evt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r <= '0;
		end else if (wr && wb_adr_i == ADR_MASK) begin
			mask_r <= wb_dat_i[NUM_CNT-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & mask_r);
		end
	end

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	// read mux; unmapped words read zero
	always_comb begin
		rd_nxt = 32'h0;
		for (int i = 0; i < NUM_CNT; i++) begin
			if (hit(wb_adr_i, ADR_CNT, NUM_CNT, i)) begin
				rd_nxt = 32'(cnt_r[i]);
			end
			if (hit(wb_adr_i, ADR_CCFG, NUM_CNT, i)) begin
				rd_nxt = ccfg_r[i];
			end
		end
		for (int i = 0; i < NUM_ESEL; i++) begin
			if (hit(wb_adr_i, ADR_ESEL, NUM_ESEL, i)) begin
				rd_nxt = esel_r[i];
			end
		end
		unique case (wb_adr_i)
			ADR_TSCLO: rd_nxt = tsc_r[31:0];
			ADR_TSCHI: rd_nxt = tsc_hi_snap_r;
			ADR_STAT:  rd_nxt = 32'(stat_r);
			ADR_MASK:  rd_nxt = 32'(mask_r);
			ADR_STATE: rd_nxt = {28'h0, pmc_on, pwr_save_r, halted_q_r};
			default:   ;
		endcase
	end

	// one wait state: ack the cycle after the request, for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= wb_req;
			if (wb_req && !wb_we_i) begin
				dat_r <= rd_nxt;
			end
		end
	end

	assign wb_ack_o    = ack_r;
	assign wb_dat_o    = dat_r;
	assign tsc_value_o = tsc_value_r;
	assign pwr_save_o  = pwr_save_r;
	assign irq_o       = irq_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	both_halted_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(&halted_q_r && !cnt_wr[0]) |=> cnt_r[0] == $past(cnt_r[0]))
		else $error("counter moved with both threads halted");

	// the last counter is the usual home of a pass-all tick count
	localparam int PA = NUM_CNT - 1;

	pass_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ccfg_r[PA][CCFG_EN] && ccfg_r[PA][CCFG_CMP] && ccfg_r[PA][CCFG_CMPL]
		&& ccfg_r[PA][CCFG_THR +: 4] == THR_ALL && pmc_on && !cnt_wr[PA]
		&& esel_r[ccfg_r[PA][CCFG_SEL +: 3]][ESEL_EVT +: 6] != EVT_NULL)
		|=> cnt_r[PA] == $past(cnt_r[PA]) + CNT_W'(1))
		else $error("pass-all filter missed a cycle");

	enable_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ccfg_r[1][CCFG_EN] && !cnt_wr[1]) [*2] |=> $stable(cnt_r[1]))
		else $error("disabled counter advanced");

	save_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(&halted_i) |=> !pwr_save_o)
		else $error("power saving with a thread running");

	tsc_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tsc_run && !wr) |=> tsc_r == $past(tsc_r) + 64'h1)
		else $error("timestamp did not advance");

	tsc_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sleep_pin_i && !wr) |=> tsc_r == $past(tsc_r))
		else $error("timestamp ran in deep sleep");

	ovf_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_evt[0] |=> stat_r[0] && ccfg_r[0][CCFG_OVF]
		##1 (irq_o || !$past(mask_r[0])))
		else $error("overflow not flagged");

	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
endmodule // ckc_counter_top
`default_nettype wire

//--- sim/test_ckc_counter_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module test_ckc_counter_top
	import ckc_pkg::*;
;
	logic             clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [ADR_W-1:0] wb_adr_i;
	logic [31:0]      wb_dat_i, wb_dat_o, q;
	logic [3:0]       wb_sel_i, ext_evt_cnt_i;
	logic [1:0]       halted_i, kernel_mode_i;
	logic             pwr_save_req_i, bus_clk_run_i, sleep_pin_i, tsc_read_i;
	logic [63:0]      tsc_value_o;
	logic             pwr_save_o, irq_o;
	logic [31:0]      exp_c [NUM_CNT];
	int               errors, check_count;

	ckc_counter_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .halted_i(halted_i),
		.kernel_mode_i(kernel_mode_i), .pwr_save_req_i(pwr_save_req_i),
		.ext_evt_cnt_i(ext_evt_cnt_i), .bus_clk_run_i(bus_clk_run_i),
		.sleep_pin_i(sleep_pin_i), .tsc_read_i(tsc_read_i),
		.tsc_value_o(tsc_value_o), .pwr_save_o(pwr_save_o), .irq_o(irq_o));

	// ****************************************************************
	// clock, watchdog, verdict
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// whole run is a few hundred cycles, so this leaves a wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		test_done();
	end

	task automatic test_done();
		$display("errors=%0d check_count=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// bus and stimulus tasks
	// ****************************************************************
	// one classic cycle; entered just after a rising edge
	task automatic wb(input logic [11:0] a, input logic we,
		input logic [31:0] d);
		int t;
		t = 0;
		wb_adr_i <= a;
		wb_we_i  <= we;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (t >= 50) begin
			errors++;
			test_done();
		end
		@(posedge clk_i);
	endtask

	// let the threads run as h for n cycles, then freeze again
	task automatic run(input logic [1:0] h, input int n);
		halted_i <= h;
		repeat (n) @(posedge clk_i);
		halted_i <= 2'b11;
		repeat (3) @(posedge clk_i);
	endtask

	// timestamp gating inputs held for n cycles, then idle
	task automatic tsc_run(input logic b, input logic s, input int n);
		bus_clk_run_i <= b;
		sleep_pin_i   <= s;
		repeat (n) @(posedge clk_i);
		bus_clk_run_i <= 1'b0;
		sleep_pin_i   <= 1'b0;
		@(posedge clk_i);
	endtask

	function automatic logic [31:0] cfg(input logic en, input logic [2:0] sel,
		input logic cmp, input logic cmpl, input logic [3:0] thr);
		return ({31'h0, en} << CCFG_EN) | ({29'h0, sel} << CCFG_SEL)
			| ({31'h0, cmp} << CCFG_CMP) | ({31'h0, cmpl} << CCFG_CMPL)
			| ({28'h0, thr} << CCFG_THR);
	endfunction

	// q order: thread0 kernel, thread0 user, thread1 kernel, thread1 user
	function automatic logic [31:0] esl(input logic [5:0] ev, input logic run,
		input logic [3:0] q4);
		return ({26'h0, ev} << ESEL_EVT) | ({31'h0, run} << ESEL_RUN)
			| {28'h0, q4};
	endfunction

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		errors = 0;
		check_count = 0;
		rst_i = 1'b1;
		{wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
		wb_sel_i = 4'hF;
		halted_i = 2'b11;
		kernel_mode_i = 2'b00;
		{pwr_save_req_i, bus_clk_run_i, sleep_pin_i, tsc_read_i} = 4'h0;
		ext_evt_cnt_i = 4'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset state of every counter and its configuration
		for (int i = 0; i < NUM_CNT; i++) begin
			wb(ADR_CCFG + 12'(4 * i), 1'b0, 32'h0);
			`CHK(q, CCFG_RST)
			wb(ADR_CNT + 12'(4 * i), 1'b0, 32'h0);
			`CHK(q, 32'h0000_0000)
			exp_c[i] = 32'h0;
		end
		// unmapped place: write ignored, reads zero
		wb(12'h200, 1'b1, 32'hA5A5_A5A5);
		wb(12'h200, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0000)
		// event selects and counter configurations, all while frozen
		wb(ADR_ESEL + 12'h000, 1'b1, esl(EVT_POWER, 1'b1, 4'hC));
		wb(ADR_ESEL + 12'h004, 1'b1, esl(EVT_POWER, 1'b1, 4'h3));
		wb(ADR_ESEL + 12'h008, 1'b1, esl(EVT_NULL, 1'b0, 4'hF));
		wb(ADR_ESEL + 12'h00C, 1'b1, esl(EVT_POWER, 1'b1, 4'h8));
		wb(ADR_ESEL + 12'h010, 1'b1, esl(6'h01, 1'b0, 4'hF));
		wb(ADR_CCFG + 12'h000, 1'b1, cfg(1'b1, 3'h0, 1'b0, 1'b0, 4'h0));
		wb(ADR_CCFG + 12'h004, 1'b1, cfg(1'b1, 3'h1, 1'b0, 1'b0, 4'h0));
		wb(ADR_CCFG + 12'h008, 1'b1, cfg(1'b1, 3'h1, 1'b1, 1'b1, THR_ALL));
		wb(ADR_CCFG + 12'h00C, 1'b1, cfg(1'b1, 3'h2, 1'b1, 1'b1, THR_ALL));
		wb(ADR_CCFG + 12'h010, 1'b1, cfg(1'b0, 3'h0, 1'b1, 1'b1, THR_ALL));
		wb(ADR_CCFG + 12'h014, 1'b1, cfg(1'b1, 3'h3, 1'b0, 1'b0, 4'h0));
		wb(ADR_CCFG + 12'h018, 1'b1, cfg(1'b1, 3'h4, 1'b1, 1'b0, 4'h5));
		wb(ADR_CCFG + 12'h01C, 1'b1, cfg(1'b1, 3'h4, 1'b1, 1'b1, 4'h5));
		wb(ADR_CCFG + 12'h020, 1'b1, cfg(1'b1, 3'h4, 1'b0, 1'b0, 4'h0));
		wb(ADR_CCFG + 12'h044, 1'b1, cfg(1'b1, 3'h0, 1'b1, 1'b1, THR_ALL));
		wb(ADR_CCFG + 12'h018, 1'b0, 32'h0);
		`CHK(q, cfg(1'b1, 3'h4, 1'b1, 1'b0, 4'h5))
		// thread0 alone, user level, no events
		run(2'b10, 6);
		// thread1 alone
		run(2'b01, 4);
		// thread0 alone at kernel level, seven events a cycle
		ext_evt_cnt_i <= 4'h7;
		kernel_mode_i <= 2'b01;
		@(posedge clk_i);
		run(2'b10, 3);
		// both halted: nothing may move
		run(2'b11, 5);
		exp_c[0] = 32'd9;
		exp_c[1] = 32'd4;
		exp_c[2] = 32'd13;
		exp_c[5] = 32'd3;
		exp_c[6] = 32'd3;
		exp_c[7] = 32'd10;
		exp_c[8] = 32'd21;
		exp_c[17] = 32'd13;
		for (int i = 0; i < NUM_CNT; i++) begin
			wb(ADR_CNT + 12'(4 * i), 1'b0, 32'h0);
			`CHK(q, exp_c[i])
		end
		// clearing the enable stops a counter
		wb(ADR_CCFG + 12'h004, 1'b1, 32'h0);
		run(2'b01, 2);
		wb(ADR_CNT + 12'h004, 1'b0, 32'h0);
		`CHK(q, 32'd4)
		// overflow of counter 0 raises the interrupt through the mask
		wb(ADR_CNT, 1'b1, 32'hFFFF_FFFE);
		wb(ADR_MASK, 1'b1, 32'h0000_0001);
		run(2'b10, 3);
		`CHK(irq_o, 1'b1)
		wb(ADR_STAT, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0001)
		wb(ADR_CNT, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0001)
		wb(ADR_CCFG, 1'b0, 32'h0);
		`CHK(q[CCFG_OVF], 1'b1)
		wb(ADR_MASK, 1'b1, 32'h0);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wb(ADR_MASK, 1'b1, 32'h0000_0001);
		wb(ADR_STAT, 1'b1, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		// timestamp: counts only with bus clock running and not asleep
		tsc_run(1'b1, 1'b0, 7);
		tsc_run(1'b1, 1'b1, 5);
		tsc_run(1'b0, 1'b0, 4);
		tsc_read_i <= 1'b1;
		@(posedge clk_i);
		tsc_read_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK(tsc_value_o, 64'h0000_0000_0000_0007)
		// carry into the high word, read back as a pair
		wb(ADR_TSCLO, 1'b1, 32'hFFFF_FFFF);
		tsc_run(1'b1, 1'b0, 2);
		wb(ADR_TSCLO, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0001)
		wb(ADR_TSCHI, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0001)
		// power saving only once both threads are halted
		pwr_save_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(pwr_save_o, 1'b1)
		// state word: counters off, saving granted, both threads halted
		wb(ADR_STATE, 1'b0, 32'h0);
		`CHK(q, 32'h0000_0007)
		halted_i <= 2'b10;
		repeat (3) @(posedge clk_i);
		`CHK(pwr_save_o, 1'b0)
		// one thread running powers the counters again
		wb(ADR_STATE, 1'b0, 32'h0);
		`CHK(q, 32'h0000_000A)
		test_done();
	end
endmodule // test_ckc_counter_top
`default_nettype wire
